/* File: design/mac_pipeline_interlock.sv */
// memory-access sequencer and multiplier interlock for accumulator loads and long MAC
`timescale 1ns/1ps
`include "mac_pipeline_interlock_defines.svh"

// How it works
// (RULE1) register accumulator load gets multiplier access stage
// (RULE2) memory accumulator load gets multiplier access stage
// (RULE3) multiplier access stretches until busy period ends
// (RULE4) register load access splits slot with fetch
// (RULE5) memory load access splits slot with fetch
// (RULE6) long MAC reads two post-incremented operands
// (RULE7) long MAC: two accesses then four busy
// (RULE8) multiplier busy four cycles after long access
// (RULE9) next decode stalls one slot after long
// (RULE10) busy count gates every multiplier access
module mac_pipeline_interlock
  import mac_pipeline_interlock_pkg::*;
(
  input  wire logic       mclk,
  input  wire logic       rst_n,
  input  wire logic       issueValid,
  input  wire logic [2:0] issueOp,
  input  wire logic       longMacEn,
  input  wire logic       fetchReq,
  output logic            seqReady,
  output logic            fetchGrant,
  output logic            memRead,
  output logic            mulAccess,
  output logic            rmIncr,
  output logic            rnIncr,
  output logic            decodeStall,
  output logic            illegalOp,
  output logic            mulBusy,
  output logic [2:0]      mulCount
);

  // ==========================================================================
  // sequencer state
  state_e     state_r,     stateNxt;
  op_e        curOp_r,     curOpNxt;
  logic [1:0] accRem_r,    accRemNxt;
  logic       fetchDone_r, fetchDoneNxt;
  logic [2:0] mulCount_r,  mulCountNxt;
  logic       accept;
  logic       illegalNxt;
  op_e        opIn;

  assign opIn = op_e'(issueOp);

  // pick the next state; every access first yields to a pending fetch
  always_comb begin
    stateNxt     = state_r;
    curOpNxt     = curOp_r;
    accRemNxt    = accRem_r;
    fetchDoneNxt = fetchDone_r;
    accept       = 1'b0;
    illegalNxt   = 1'b0;
    case (state_r)
      ST_IDLE: begin
        if (issueValid && (opIn == OP_MACL) && !longMacEn) begin
          illegalNxt = 1'b1;  // long MAC only on the later series
        end else if (issueValid && (opIn != OP_NONE)) begin
          accept   = 1'b1;
          curOpNxt = opIn;
          if ((opIn == OP_MACW) || (opIn == OP_MACL)) begin
            accRemNxt = `ACC_TWO;  // RULE7
          end else begin
            accRemNxt = `ACC_FINAL;  // RULE1
          end
        end
      end
      ST_FETCH: fetchDoneNxt = 1'b1;
      ST_HOLD:  ;
      ST_MEM: begin
        accRemNxt    = accRem_r - `ACC_FINAL;
        fetchDoneNxt = 1'b0;
      end
      ST_MUL: begin
        accRemNxt    = `ACC_NONE;
        fetchDoneNxt = 1'b0;
      end
      default: begin
        accRemNxt    = `ACC_NONE;
        fetchDoneNxt = 1'b0;
      end
    endcase
    // route the owed access; fetch gets its own slot first
    if (accRemNxt != `ACC_NONE) begin
      if (fetchReq && !fetchDoneNxt) begin
        stateNxt = ST_FETCH;  // RULE4 RULE5
      end else if ((accRemNxt == `ACC_FINAL) && (mulCount_r != `BUSY_NONE_CYC)) begin
        stateNxt = ST_HOLD;  // RULE3 RULE10
      end else if (accRemNxt == `ACC_FINAL) begin
        stateNxt = ST_MUL;  // RULE1 RULE2
      end else begin
        stateNxt = ST_MEM;
      end
    end else begin
      stateNxt = ST_IDLE;
    end
  end

  // busy counter runs on its own, regardless of slot boundaries
  always_comb begin
    mulCountNxt = `BUSY_NONE_CYC;
    if (mulAccess) begin
      case (curOp_r)
        OP_MACL: mulCountNxt = `BUSY_LONG_CYC;  // RULE8
        OP_MACW: mulCountNxt = `BUSY_WORD_CYC;
        default: mulCountNxt = `BUSY_NONE_CYC;  // accumulator loads leave it idle
      endcase
    end else if (mulCount_r != `BUSY_NONE_CYC) begin
      mulCountNxt = mulCount_r - `BUSY_ONE_CYC;  // RULE10
    end
  end

  // state registers
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      state_r     <= ST_IDLE;
      curOp_r     <= OP_NONE;
      accRem_r    <= `ACC_NONE;
      fetchDone_r <= 1'b0;
      mulCount_r  <= `BUSY_NONE_CYC;
    end else begin
      state_r     <= stateNxt;
      curOp_r     <= curOpNxt;
      accRem_r    <= accRemNxt;
      fetchDone_r <= fetchDoneNxt;
      mulCount_r  <= mulCountNxt;
    end
  end

  // ==========================================================================
  // registered outputs, decoded from the next state so they line up with it
  logic seqReadyNxt, fetchGrantNxt, memReadNxt, mulAccessNxt;
  logic rmIncrNxt, rnIncrNxt, decodeStallNxt;
  logic mulBusyNxt;

  always_comb begin
    seqReadyNxt    = (stateNxt == ST_IDLE);
    fetchGrantNxt  = (stateNxt == ST_FETCH);
    // register-form load touches only the multiplier in its access
    memReadNxt     = (stateNxt == ST_MEM) ||
                     ((stateNxt == ST_MUL) && (curOpNxt != OP_LDSR));  // RULE2
    mulAccessNxt   = (stateNxt == ST_MUL);
    rmIncrNxt      = (stateNxt == ST_MEM) && (curOpNxt == OP_MACL) &&
                     (accRemNxt == `ACC_TWO);  // RULE6
    rnIncrNxt      = (stateNxt == ST_MUL) && (curOpNxt == OP_MACL);  // RULE6 RULE7
    decodeStallNxt = accept && (opIn == OP_MACL);  // RULE9
    // busy flag follows the count it is registered with
    mulBusyNxt     = (mulCountNxt != `BUSY_NONE_CYC);  // RULE10
  end

  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      seqReady    <= 1'b1;
      fetchGrant  <= 1'b0;
      memRead     <= 1'b0;
      mulAccess   <= 1'b0;
      rmIncr      <= 1'b0;
      rnIncr      <= 1'b0;
      decodeStall <= 1'b0;
      illegalOp   <= 1'b0;
      mulBusy     <= 1'b0;
      mulCount    <= `BUSY_NONE_CYC;
    end else begin
      seqReady    <= seqReadyNxt;
      fetchGrant  <= fetchGrantNxt;
      memRead     <= memReadNxt;
      mulAccess   <= mulAccessNxt;
      rmIncr      <= rmIncrNxt;
      rnIncr      <= rnIncrNxt;
      decodeStall <= decodeStallNxt;
      illegalOp   <= illegalNxt;
      mulBusy     <= mulBusyNxt;
      mulCount    <= mulCountNxt;
    end
  end

  // ==========================================================================
  // checks
  AST_LDSR_ACCESS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE1
    (seqReady && issueValid && (opIn == OP_LDSR) && !fetchReq && !mulBusy)
      |=> (mulAccess && !memRead) ##1 seqReady)
    else $error("register accumulator load missed its multiplier access");

  AST_LDSM_ACCESS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE2
    (mulAccess && (curOp_r == OP_LDSM)) |-> memRead)
    else $error("memory accumulator load access did not read memory");

  AST_STRETCH: assert property (@(posedge mclk) disable iff (!rst_n) // RULE3
    (state_r == ST_HOLD) |-> (!mulAccess && !memRead)
      ##1 (($past(mulCount_r) != `BUSY_NONE_CYC) || mulAccess || fetchGrant))
    else $error("stretched multiplier access ended wrongly");

  AST_FETCH_SPLIT: assert property (@(posedge mclk) disable iff (!rst_n) // RULE4
    fetchGrant |-> (!memRead && !mulAccess) ##1 !fetchGrant)
    else $error("fetch shared a slot with a memory access");

  AST_FETCH_FIRST: assert property (@(posedge mclk) disable iff (!rst_n) // RULE5
    (seqReady && issueValid && (opIn == OP_LDSM) && fetchReq) |=> fetchGrant)
    else $error("memory accumulator load did not yield to fetch");

  AST_LONG_OPERANDS: assert property (@(posedge mclk) disable iff (!rst_n) // RULE6
    (seqReady && issueValid && (opIn == OP_MACL) && longMacEn)
      |-> ##[1:4] rmIncr ##[1:40] rnIncr)
    else $error("long MAC did not step both address registers");

  AST_LONG_BUSY: assert property (@(posedge mclk) disable iff (!rst_n) // RULE8
    (mulAccess && (curOp_r == OP_MACL)) |=> (mulCount == `BUSY_LONG_CYC) ##1 (mulCount == 3'h3)
      ##1 (mulCount == 3'h2) ##1 (mulCount == 3'h1) ##1 !mulBusy)
    else $error("long MAC busy period is not four cycles");

  AST_SECOND_READ: assert property (@(posedge mclk) disable iff (!rst_n) // RULE7
    rnIncr |-> (memRead && mulAccess && !$past(mulBusy)))
    else $error("second long MAC access did not read and multiply");

  AST_DECODE_STALL: assert property (@(posedge mclk) disable iff (!rst_n) // RULE9
    (seqReady && issueValid && (opIn == OP_MACL) && longMacEn)
      |=> decodeStall ##1 !decodeStall)
    else $error("decode stall after long MAC is not one slot");

  AST_BUSY_GATE: assert property (@(posedge mclk) disable iff (!rst_n) // RULE10
    $rose(mulAccess) |-> ($past(mulCount) == `BUSY_NONE_CYC))
    else $error("multiplier accessed with a nonzero busy count");

endmodule : mac_pipeline_interlock

/* File: dv/fetch_port_model.sv */
// fetch side of the shared memory port, asking for the port on command
`timescale 1ns/1ps

// ==========================================================================
// fetch requester
module fetch_port_model (
  input  wire logic mclk,
  input  wire logic contend,
  output logic      fetchReq
);
  // request changes only at the falling edge, clear of the sampling edge;
  // it is unknown only before the first falling edge, inside reset
  always @(negedge mclk) begin
    fetchReq <= contend;
  end
endmodule : fetch_port_model

/* File: dv/testbench.sv */
// self-checking bench for the multiply/accumulate interlock
`timescale 1ns/1ps

// ==========================================================================
// bench top
module testbench;
  import mac_pipeline_interlock_pkg::*;
  logic       mclk = 1'b0;
  logic       rst_n = 1'b0;
  logic       issueValid = 1'b0;
  logic [2:0] issueOp = 3'h0;
  logic       longMacEn = 1'b1;
  logic       contend = 1'b0;
  logic       fetchReq;
  logic       seqReady, fetchGrant, memRead, mulAccess;
  logic       rmIncr, rnIncr, decodeStall, illegalOp, mulBusy;
  logic [2:0] mulCount;
  int         fails = 0;
  int         n_checks = 0;
  int         cyc = 0;

  initial forever #5 mclk = ~mclk;

  fetch_port_model i_fetch (.mclk(mclk), .contend(contend), .fetchReq(fetchReq));

  mac_pipeline_interlock i_dut (
    .mclk(mclk), .rst_n(rst_n), .issueValid(issueValid), .issueOp(issueOp),
    .longMacEn(longMacEn), .fetchReq(fetchReq), .seqReady(seqReady),
    .fetchGrant(fetchGrant), .memRead(memRead), .mulAccess(mulAccess),
    .rmIncr(rmIncr), .rnIncr(rnIncr), .decodeStall(decodeStall),
    .illegalOp(illegalOp), .mulBusy(mulBusy), .mulCount(mulCount));

  // ==========================================================================
  // helpers
  task automatic chk(input string name, input logic [2:0] exp, input logic [2:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("MISMATCH %s expected %0h seen %0h", name, exp, got);
    end
  endtask : chk

  // present one instruction, return in cycle 1 after the take edge
  task automatic issue(input logic [2:0] op);
    @(negedge mclk);
    issueValid = 1'b1;
    issueOp = op;
    @(posedge mclk);
    @(negedge mclk);
    issueValid = 1'b0;
    issueOp = 3'h0;
  endtask : issue

  // bounded wait for the sequencer and the multiplier to settle
  task automatic wait_idle();
    for (int i = 0; i < 20 && !(seqReady === 1'b1 && mulBusy === 1'b0); i++) @(negedge mclk);
  endtask : wait_idle

  task automatic close_out();
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : close_out

  // ==========================================================================
  // scenarios
  task automatic t_long_mac();
    issue(OP_MACL);
    chk("c1 memRead", 3'h1, memRead);
    chk("c1 rmIncr", 3'h1, rmIncr);
    chk("c1 decodeStall", 3'h1, decodeStall);
    @(negedge mclk);
    chk("c2 mulAccess", 3'h1, mulAccess);
    chk("c2 rnIncr", 3'h1, rnIncr);
    chk("c2 decodeStall", 3'h0, decodeStall);
    @(negedge mclk);
    chk("c3 mulCount", 3'h4, mulCount);
    repeat (3) @(negedge mclk);
    chk("c6 mulBusy", 3'h1, mulBusy);
    @(negedge mclk);
    chk("c7 mulBusy", 3'h0, mulBusy);
  endtask : t_long_mac

  // register-form load right behind a word MAC must hold for the busy period
  task automatic t_load_after_word();
    issue(OP_MACW);
    @(negedge mclk);
    chk("word mulAccess", 3'h1, mulAccess);
    // load is taken on the edge where the busy count steps from 2 down to 1
    issue(OP_LDSR);
    chk("hold1 mulAccess", 3'h0, mulAccess);
    chk("hold1 seqReady", 3'h0, seqReady);
    @(negedge mclk);
    chk("hold2 mulAccess", 3'h0, mulAccess);
    @(negedge mclk);
    chk("load mulAccess", 3'h1, mulAccess);
    chk("load memRead", 3'h0, memRead);
  endtask : t_load_after_word

  // with fetch asking, the load's access takes the slot after the fetch
  task automatic t_load_split(input logic [2:0] op, input logic [2:0] rd);
    contend = 1'b1;
    issue(op);
    chk("split fetchGrant", 3'h1, fetchGrant);
    chk("split early access", 3'h0, mulAccess);
    contend = 1'b0;
    @(negedge mclk);
    chk("split mulAccess", 3'h1, mulAccess);
    chk("split memRead", rd, memRead);
  endtask : t_load_split

  // idle multiplier, no fetch: the access comes in the first cycle after the take
  task automatic t_load_plain(input logic [2:0] op, input logic [2:0] rd);
    issue(op);
    chk("plain mulAccess", 3'h1, mulAccess);
    chk("plain memRead", rd, memRead);
    chk("plain fetchGrant", 3'h0, fetchGrant);
    @(negedge mclk);
    chk("plain seqReady", 3'h1, seqReady);
    chk("plain mulBusy", 3'h0, mulBusy);
  endtask : t_load_plain

  task automatic t_long_refused();
    longMacEn = 1'b0;
    issue(OP_MACL);
    chk("illegalOp", 3'h1, illegalOp);
    chk("refused memRead", 3'h0, memRead);
    longMacEn = 1'b1;
  endtask : t_long_refused

  // ==========================================================================
  // main sequence and watchdog
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 2000) begin
      fails++;
      close_out();
    end
  end

  initial begin
    repeat (5) @(negedge mclk);
    rst_n = 1'b1;
    t_long_mac();
    wait_idle();
    t_load_after_word();
    wait_idle();
    t_load_split(OP_LDSM, 3'h1);
    wait_idle();
    t_load_split(OP_LDSR, 3'h0);
    wait_idle();
    t_long_refused();
    wait_idle();
    t_load_plain(OP_LDSR, 3'h0);
    wait_idle();
    t_load_plain(OP_LDSM, 3'h1);
    wait_idle();
    close_out();
  end
endmodule : testbench

/* File: inc/mac_pipeline_interlock_defines.svh */
// timing counts and access counts for the multiply/accumulate interlock
`ifndef MAC_PIPELINE_INTERLOCK_DEFINES_SVH
`define MAC_PIPELINE_INTERLOCK_DEFINES_SVH

// ==========================================================================
// multiplier busy periods after the final multiplier access
`define BUSY_WORD_CYC  3'h2
`define BUSY_LONG_CYC  3'h4
`define BUSY_NONE_CYC  3'h0
`define BUSY_ONE_CYC   3'h1

// ==========================================================================
// memory-access stages owed by each instruction class
`define ACC_TWO        2'h2
`define ACC_FINAL      2'h1
`define ACC_NONE       2'h0

`endif

/* File: inc/mac_pipeline_interlock_pkg.sv */
// types shared by the multiply/accumulate interlock
package mac_pipeline_interlock_pkg;

  // ==========================================================================
  // instruction classes presented at the operate stage
  typedef enum logic [2:0] {
    OP_NONE = 3'b000,
    OP_MACW = 3'b001,  // multiply_accumulate_word
    OP_MACL = 3'b010,  // multiply_accumulate_long
    OP_LDSR = 3'b011,  // load_to_system_reg from a general register
    OP_LDSM = 3'b100   // load_to_system_reg_from_memory
  } op_e;

  // ==========================================================================
  // memory-access sequencer states
  typedef enum logic [2:0] {
    ST_IDLE  = 3'b000,
    ST_FETCH = 3'b001,  // slot given to instruction fetch before the access
    ST_MEM   = 3'b010,  // plain memory_access_stage
    ST_HOLD  = 3'b011,  // multiplier access stretched while busy
    ST_MUL   = 3'b100   // memory_access_stage touching the multiplier
  } state_e;

endpackage : mac_pipeline_interlock_pkg
